/* hdl/peripheral_clock_gate_control.sv */
// Peripheral module off control: register bank, clock gates, SFR guard
//
// Notes on behaviour
// - A set off bit stops every clock into that peripheral.
// - While a peripheral is off its register writes are dropped and reads are marked invalid.
// - Writing one turns a peripheral off, writing zero turns it on, and all bits are zero after reset.
// - A set off bit holds the peripheral's registers in reset, a clear bit lets its clocks run.
// - Compare units 9 to 16 sit in bits 24 to 31 of the third bank, one bit each.
// - Timers 1 to 9 sit in bits 0 to 8 of the fourth bank in number order.
// - Pulse generators 1 to 12 sit in bits 16 to 27 of the fourth bank in number order.
// - Serial ports 1 to 6 sit in bits 0 to 5 of the fifth bank in number order.
// - Synchronous serial ports 1 to 4 sit in bits 8 to 11 of the fifth bank in number order.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module peripheral_clock_gate_control
    import periph_gate_pkg::*;
#(
    parameter int UNITS = PERIPH_NUM
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    output logic [DATA_W-1:0] reg_rd_data_q,
    // Peripheral SFR access requests
    input wire logic [UNITS-1:0] sfr_wr_req,
    input wire logic [UNITS-1:0] sfr_rd_req,
    // Peripheral side
    output logic [UNITS-1:0] periph_clk,
    output logic [UNITS-1:0] periph_rst_n_q,
    output logic [UNITS-1:0] sfr_wr_q,
    output logic [UNITS-1:0] sfr_rd_valid_q
);

    logic [DATA_W-1:0] bank3_q;
    logic [DATA_W-1:0] bank4_q;
    logic [DATA_W-1:0] bank5_q;
    logic [UNITS-1:0] module_off_bit;
    logic [UNITS-1:0] run_vec;
    logic [DATA_W-1:0] run3;
    logic [DATA_W-1:0] run4;
    logic [DATA_W-1:0] run5;
    logic [DATA_W-1:0] rd_mux;
    reg_sel_type wr_sel;
    reg_sel_type rd_sel;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
        reg_sel_type s;
        s = SEL_NONE;
        case (a)
            BANK3_OFFSET: s = SEL_BANK3;
            BANK4_OFFSET: s = SEL_BANK4;
            BANK5_OFFSET: s = SEL_BANK5;
            RUN3_OFFSET: s = SEL_RUN3;
            RUN4_OFFSET: s = SEL_RUN4;
            RUN5_OFFSET: s = SEL_RUN5;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    // Copies a run of bits from the flat vector into a bank layout
    function automatic logic [DATA_W-1:0] place(
        input logic [DATA_W-1:0] word,
        input logic [UNITS-1:0] vec,
        input int base,
        input int lsb,
        input int num
    );
        logic [DATA_W-1:0] w;
        w = word;
        for (int i = 0; i < num; i++)
        begin
            w[lsb + i] = vec[base + i];
        end
        return w;
    endfunction : place

    assign wr_sel = reg_wr_stb ? decode(reg_addr) : SEL_NONE;
    assign rd_sel = decode(reg_addr);

    // ------------------------------------------------------------------
    // Off banks; unimplemented bits never store, so they read zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bank3_q <= BANK_RESET;
            bank4_q <= BANK_RESET;
            bank5_q <= BANK_RESET;
        end
        else if (clk_en)
        begin
            case (wr_sel)
                SEL_BANK3: bank3_q <= reg_wr_data & BANK3_MASK;
                SEL_BANK4: bank4_q <= reg_wr_data & BANK4_MASK;
                SEL_BANK5: bank5_q <= reg_wr_data & BANK5_MASK;
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bank bits to flat peripheral vector
    // ------------------------------------------------------------------
    always_comb
    begin
        module_off_bit = '0;
        for (int i = 0; i < COMPARE_NUM; i++)
        begin
            module_off_bit[COMPARE_BASE + i] = bank3_q[COMPARE_LSB + i];
        end
        for (int i = 0; i < TIMER_NUM; i++)
        begin
            module_off_bit[TIMER_BASE + i] = bank4_q[TIMER_LSB + i];
        end
        for (int i = 0; i < PULSE_NUM; i++)
        begin
            module_off_bit[PULSE_BASE + i] = bank4_q[PULSE_LSB + i];
        end
        for (int i = 0; i < SERIAL_NUM; i++)
        begin
            module_off_bit[SERIAL_BASE + i] = bank5_q[SERIAL_LSB + i];
        end
        for (int i = 0; i < SYNC_NUM; i++)
        begin
            module_off_bit[SYNC_BASE + i] = bank5_q[SYNC_LSB + i];
        end
    end

    // ------------------------------------------------------------------
    // One gate per peripheral; none shares state with another
    // ------------------------------------------------------------------
    for (genvar g = 0; g < UNITS; g++)
    begin : gate_g
        periph_clock_gate u_gate (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .gate_off(module_off_bit[g]),
            .gated_clk(periph_clk[g]),
            .sfr_rst_n_q(periph_rst_n_q[g]),
            .run_q(run_vec[g])
        );
    end

    // ------------------------------------------------------------------
    // Run status in the same layout as the banks
    // ------------------------------------------------------------------
    always_comb
    begin
        run3 = place(READ_IDLE, run_vec, COMPARE_BASE, COMPARE_LSB,
            COMPARE_NUM);
        run4 = place(READ_IDLE, run_vec, TIMER_BASE, TIMER_LSB, TIMER_NUM);
        run4 = place(run4, run_vec, PULSE_BASE, PULSE_LSB, PULSE_NUM);
        run5 = place(READ_IDLE, run_vec, SERIAL_BASE, SERIAL_LSB,
            SERIAL_NUM);
        run5 = place(run5, run_vec, SYNC_BASE, SYNC_LSB, SYNC_NUM);
    end

    always_comb
    begin
        case (rd_sel)
            SEL_BANK3: rd_mux = bank3_q;
            SEL_BANK4: rd_mux = bank4_q;
            SEL_BANK5: rd_mux = bank5_q;
            SEL_RUN3: rd_mux = run3;
            SEL_RUN4: rd_mux = run4;
            SEL_RUN5: rd_mux = run5;
            default: rd_mux = READ_IDLE;
        endcase
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_rd_data_q <= READ_IDLE;
        end
        else if (clk_en)
        begin
            reg_rd_data_q <= reg_rd_stb ? rd_mux : READ_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // SFR guard; checks the off bit as well as the held reset, so a
    // write in the very cycle of switching off is already dropped
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sfr_wr_q <= '0;
            sfr_rd_valid_q <= '0;
        end
        else if (clk_en)
        begin
            sfr_wr_q <= sfr_wr_req & ~module_off_bit & periph_rst_n_q;
            sfr_rd_valid_q <= sfr_rd_req & ~module_off_bit
                & periph_rst_n_q;
        end
    end

endmodule : peripheral_clock_gate_control

`default_nettype wire

/* hdl/periph_gate_pkg.sv */
// Constants and types shared by the peripheral clock gate control block
package periph_gate_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] BANK3_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] BANK4_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] BANK5_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] RUN3_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] RUN4_OFFSET = 8'h14;
    localparam logic [ADDR_W-1:0] RUN5_OFFSET = 8'h18;

    // ------------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] BANK3_MASK = 32'hff00_0000;
    localparam logic [DATA_W-1:0] BANK4_MASK = 32'h0fff_01ff;
    localparam logic [DATA_W-1:0] BANK5_MASK = 32'h0000_0f3f;
    localparam logic [DATA_W-1:0] BANK_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field positions inside the banks
    // ------------------------------------------------------------------
    localparam int COMPARE_LSB = 24;
    localparam int TIMER_LSB = 0;
    localparam int PULSE_LSB = 16;
    localparam int SERIAL_LSB = 0;
    localparam int SYNC_LSB = 8;

    // ------------------------------------------------------------------
    // Unit counts and their place in the flat peripheral vector
    // ------------------------------------------------------------------
    localparam int COMPARE_NUM = 8;
    localparam int TIMER_NUM = 9;
    localparam int PULSE_NUM = 12;
    localparam int SERIAL_NUM = 6;
    localparam int SYNC_NUM = 4;
    localparam int COMPARE_BASE = 0;
    localparam int TIMER_BASE = COMPARE_BASE + COMPARE_NUM;
    localparam int PULSE_BASE = TIMER_BASE + TIMER_NUM;
    localparam int SERIAL_BASE = PULSE_BASE + PULSE_NUM;
    localparam int SYNC_BASE = SERIAL_BASE + SERIAL_NUM;
    localparam int PERIPH_NUM = SYNC_BASE + SYNC_NUM;

    // ------------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------------
    typedef enum {
        SEL_NONE,
        SEL_BANK3,
        SEL_BANK4,
        SEL_BANK5,
        SEL_RUN3,
        SEL_RUN4,
        SEL_RUN5
    } reg_sel_type;

endpackage : periph_gate_pkg

/* hdl/periph_clock_gate.sv */
// Glitch-free clock gate and reset hold for one peripheral
`timescale 1ns/1ns
`default_nettype none

module periph_clock_gate
    import periph_gate_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Control
    input wire logic gate_off,
    // Peripheral side
    output logic gated_clk,
    output logic sfr_rst_n_q,
    output logic run_q
);

    logic off_dly_q;
    logic en_lo_q;

    // ------------------------------------------------------------------
    // Sequencing: reset goes on before the clock stops, and comes off
    // only after the clock has run again, so the peripheral sees it
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            off_dly_q <= 1'b0;
            sfr_rst_n_q <= 1'b0;
            run_q <= 1'b1;
        end
        else if (clk_en)
        begin
            off_dly_q <= gate_off;
            sfr_rst_n_q <= ~(gate_off | off_dly_q);
            run_q <= ~(gate_off & off_dly_q);
        end
    end

    // ------------------------------------------------------------------
    // Enable changes only while the clock is low, so no pulse is cut
    // ------------------------------------------------------------------
    always_ff @(negedge clk_sys)
    begin
        if (!rst_n)
        begin
            en_lo_q <= 1'b1;
        end
        else if (clk_en)
        begin
            en_lo_q <= run_q;
        end
    end

    assign gated_clk = clk_sys & en_lo_q;

endmodule : periph_clock_gate

`default_nettype wire

/* sim/periph_gate_monitor.sv */
// Port checker for the peripheral clock gate control block
`timescale 1ns/1ns
`default_nettype none
module periph_gate_monitor
    import periph_gate_pkg::*;
#(
    parameter int UNITS = PERIPH_NUM
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [DATA_W-1:0] reg_rd_data_q,
    // Peripheral side
    input wire logic [UNITS-1:0] sfr_wr_req,
    input wire logic [UNITS-1:0] sfr_rd_req,
    input wire logic [UNITS-1:0] periph_clk,
    input wire logic [UNITS-1:0] periph_rst_n_q,
    input wire logic [UNITS-1:0] sfr_wr_q,
    input wire logic [UNITS-1:0] sfr_rd_valid_q
);
    // ----
    // A taken write lands in the bank at its edge; the held reset shows
    // one edge later, so it is looked at two edges after the strobe
    // ----
    sequence s_wr(logic [ADDR_W-1:0] a);
        clk_en && reg_wr_stb && reg_addr == a;
    endsequence
    property p_bank3;
        @(posedge clk_sys) disable iff (!rst_n)
        s_wr(BANK3_OFFSET) |=> ##1
            (periph_rst_n_q[7:0] & $past(reg_wr_data[31:24], 2)) == '0;
    endproperty
    a_bank3: assert property (p_bank3) else $error("compare reset late");
    property p_bank4;
        @(posedge clk_sys) disable iff (!rst_n)
        s_wr(BANK4_OFFSET) |=> ##1
            (periph_rst_n_q[28:8]
            & $past({reg_wr_data[27:16], reg_wr_data[8:0]}, 2)) == '0;
    endproperty
    a_bank4: assert property (p_bank4) else $error("bank4 reset late");
    property p_bank5;
        @(posedge clk_sys) disable iff (!rst_n)
        s_wr(BANK5_OFFSET) |=> ##1
            (periph_rst_n_q[38:29]
            & $past({reg_wr_data[11:8], reg_wr_data[5:0]}, 2)) == '0;
    endproperty
    a_bank5: assert property (p_bank5) else $error("bank5 reset late");
    property p_wr_refuse;
        @(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr_q & ~$past(sfr_wr_req & periph_rst_n_q)) == '0;
    endproperty
    a_wr_refuse: assert property (p_wr_refuse) else $error("write leaked");
    property p_rd_refuse;
        @(posedge clk_sys) disable iff (!rst_n)
        (sfr_rd_valid_q & ~$past(sfr_rd_req & periph_rst_n_q)) == '0;
    endproperty
    a_rd_refuse: assert property (p_rd_refuse) else $error("read valid");
    property p_rd_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        !reg_rd_stb |=> reg_rd_data_q == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
    property p_rst_release;
        @(posedge clk_sys) disable iff (!rst_n)
        !$past(rst_n) && !reg_wr_stb |=> periph_rst_n_q == '1;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("not on");
    // High phase sampled at the falling edge; a unit held off for four
    // falling edges must show no clock pulse in the high phase ending at the third
    property p_clk_off;
        @(negedge clk_sys) disable iff (!rst_n)
        $past(rst_n, 3) |-> ($past(periph_clk) & ~periph_rst_n_q
            & ~$past(periph_rst_n_q) & ~$past(periph_rst_n_q, 2)
            & ~$past(periph_rst_n_q, 3)) == '0;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock not cut");
endmodule : periph_gate_monitor
bind peripheral_clock_gate_control periph_gate_monitor #(.UNITS(UNITS)) u_mon (
    .clk_sys, .rst_n, .clk_en, .reg_addr, .reg_wr_data, .reg_wr_stb,
    .reg_rd_stb,
    .reg_rd_data_q, .sfr_wr_req, .sfr_rd_req, .periph_clk, .periph_rst_n_q,
    .sfr_wr_q, .sfr_rd_valid_q);
`default_nettype wire

/* sim/periph_far_model.sv */
// Far-side model: gated peripherals counting their own clock edges
`timescale 1ns/1ns
`default_nettype none
module periph_far_model
    import periph_gate_pkg::*;
#(
    parameter int UNITS = PERIPH_NUM
)
(
    // Gated clocks
    input wire logic [UNITS-1:0] periph_clk
);
    int cnt [UNITS];
    for (genvar k = 0; k < UNITS; k++)
    begin : g_unit
        // Ticks only on its own clock, so a stopped gate freezes it
        initial cnt[k] = 0;
        always @(posedge periph_clk[k])
        begin
            cnt[k] <= cnt[k] + 1;
        end
    end
endmodule : periph_far_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking testbench for the peripheral clock gate control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import periph_gate_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wr_data = '0;
    logic reg_wr_stb = 1'b0;
    logic reg_rd_stb = 1'b0;
    logic [DATA_W-1:0] reg_rd_data_q;
    logic [PERIPH_NUM-1:0] sfr_wr_req = '0;
    logic [PERIPH_NUM-1:0] sfr_rd_req = '0;
    logic [PERIPH_NUM-1:0] periph_clk, periph_rst_n_q, sfr_wr_q;
    logic [PERIPH_NUM-1:0] sfr_rd_valid_q, off, on_bits, wq, rq, mv;
    logic [31:0] b3, b4, b5;
    logic [63:0] r;
    logic rd_q = 1'b0;
    logic [DATA_W-1:0] exp_q [$];
    int seed = 32'h09643fe2;
    int bad_count = 0;
    int n_tests = 0;
    int snap [PERIPH_NUM];
    peripheral_clock_gate_control DUT (.clk_sys, .rst_n, .clk_en, .reg_addr,
        .reg_wr_data, .reg_wr_stb, .reg_rd_stb, .reg_rd_data_q, .sfr_wr_req,
        .sfr_rd_req, .periph_clk, .periph_rst_n_q, .sfr_wr_q, .sfr_rd_valid_q);
    periph_far_model FAR (.periph_clk(periph_clk));
    initial forever #5 clk_sys = ~clk_sys;
    // ----
    // Bus tasks: each assigns both strobes once, so they chain freely
    // ----
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_stb <= 1'b1;
        reg_rd_stb <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_wr_stb <= 1'b0;
        reg_rd_stb <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
    endtask : rd
    task automatic idle(input int n);
        reg_wr_stb <= 1'b0;
        reg_rd_stb <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask : idle
    task automatic check(input string nm, input logic [63:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (rd_q)
            check("rd_data", reg_rd_data_q, exp_q.pop_front());
        rd_q <= reg_rd_stb;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(BANK3_OFFSET, '0);
        rd(BANK4_OFFSET, '0);
        rd(BANK5_OFFSET, '0);
        wr(8'h0c, '1);
        rd(8'h0c, '0);
        // Enable low: the write must not land
        clk_en <= 1'b0;
        wr(BANK3_OFFSET, '1);
        clk_en <= 1'b1;
        rd(BANK3_OFFSET, '0);
        for (int i = 0; i < 6; i++)
        begin
            b3 = $random(seed);
            b4 = $random(seed);
            b5 = $random(seed);
            if (i == 0) {b3, b4, b5} = '1;
            if (i == 1) {b3, b4, b5} = '0;
            wr(BANK3_OFFSET, b3);
            wr(BANK4_OFFSET, b4);
            wr(BANK5_OFFSET, b5);
            wr(RUN4_OFFSET, '1);
            rd(BANK3_OFFSET, b3 & BANK3_MASK);
            rd(BANK4_OFFSET, b4 & BANK4_MASK);
            rd(BANK5_OFFSET, b5 & BANK5_MASK);
            rd(RUN4_OFFSET, ~b4 & BANK4_MASK);
            idle(4);
            off = {b5[11:8], b5[5:0], b4[27:16], b4[8:0], b3[31:24]};
            // Inverted at unit width, so the wide compare sees no ones above
            on_bits = ~off;
            check("sfr_reset", periph_rst_n_q, on_bits);
            foreach (snap[k]) snap[k] = FAR.cnt[k];
            idle(10);
            foreach (snap[k]) mv[k] = FAR.cnt[k] != snap[k];
            check("clock_run", mv, on_bits);
            r = {$random(seed), $random(seed)};
            wq = r[PERIPH_NUM-1:0];
            r = {$random(seed), $random(seed)};
            rq = r[PERIPH_NUM-1:0];
            sfr_wr_req <= wq;
            sfr_rd_req <= rq;
            @(posedge clk_sys);
            // Peripheral traffic stops before the next off bits are written
            sfr_wr_req <= '0;
            sfr_rd_req <= '0;
            #1 check("sfr_wr", sfr_wr_q, wq & ~off);
            check("sfr_rd", sfr_rd_valid_q, rq & ~off);
        end
        idle(3);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
